/* File: verilog/rigc_defines.svh */
`ifndef RIGC_DEFINES_SVH
`define RIGC_DEFINES_SVH
// Behaviour
// - chip select low enables flash, boot block, SRAM and I/O registers.
// - chip select high disables memories; logic array and I/O keep running.
// - bit 4 of power_gating_reg_a disconnects common_logic_clock from the array.
// - bits 2..6 of input_block_reg_b block bus controls, ALE, byte enable.
// - blocking controls from the array never blocks them to memory and I/O.
// - power-on reset loads configuration, clears registers, readies the flash.
// - device stays in reset 120 ns after reset rises; no access before.
// - flash starts in read array mode at power up.
// - flash write start is blocked while supply is below lockout.
// - warm reset applies the same recovery interval before the first access.
// - logic outputs valid through warm reset, valid after config at power-on.
// - reset: I/O inputs, address and data float; power down: I/O holds.
// - power-on clears power registers, warm keeps them; memory map reloads; PD keeps.
// - either reset loads memory map default with SRAM code bit cleared.
// - reset during program or erase aborts and returns to read in 25 us.
// - chip select low or reset rising leaves power down mode.

// *************************************
// field positions and reset values
// *************************************
`define RIGC_PMA_CLK_BLOCK_BIT 4
`define RIGC_PMB_FIRST_BIT 2
`define RIGC_PMB_LAST_BIT 6
`define RIGC_MM_SRAM_CODE_BIT 0
`define RIGC_PM_RESET_VAL 8'h00

// *************************************
// timing
// *************************************
`define RIGC_CLK_PERIOD_NS 10
`define RIGC_RECOVERY_NS 120
`define RIGC_RECOVERY_CYC (`RIGC_RECOVERY_NS / `RIGC_CLK_PERIOD_NS)
`define RIGC_ABORT_US 25
`define RIGC_ABORT_CYC ((`RIGC_ABORT_US * 1000) / `RIGC_CLK_PERIOD_NS)
`endif

/* File: verilog/rigc_pkg.sv */
package rigc_pkg;
    typedef enum logic [2:0] {
        PH_RUN = 3'b001,
        PH_RESET = 3'b010,
        PH_RECOVER = 3'b100
    } rigc_phase_e;

    typedef struct packed {
        logic data_byte_enable;
        logic ale;
        logic [2:0] bus_control;
    } rigc_ctrl_s;

    typedef struct packed {
        rigc_phase_e phase;
        logic powered;
        logic cfg_loaded;
        logic pd;
        logic [3:0] rec_cnt;
        logic [11:0] abort_cnt;
        logic aborting;
        logic flash_read_mode;
        logic [7:0] pm_a;
        logic [7:0] pm_b;
        logic [7:0] mm;
        logic [7:0] io_oe;
        logic addr_oe;
        logic data_oe;
    } rigc_state_s;
endpackage

/* File: verilog/rigc_sync.sv */
module rigc_sync #(
    parameter int W = 1,
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } rigc_sync_s;

    rigc_sync_s state_reg;
    rigc_sync_s state_next;

    initial begin
        if (W < 1) begin
            $error("rigc_sync: W must be at least 1");
        end
    end

    always_comb begin
        state_next.s1 = async_in;
        state_next.s2 = state_reg.s1;
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_reg <= '{s1: {W{RST_VAL}}, s2: {W{RST_VAL}}};
        end else begin
            state_reg <= state_next;
        end
    end

    assign sync_out = state_reg.s2;
endmodule

/* File: verilog/rigc_ctrl.sv */
`include "rigc_defines.svh"

module rigc_ctrl #(
    parameter int PORT_W = 8
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // pins from the board
    input wire logic ext_reset_n_in,
    input wire logic chip_select_pin_n_in,
    input wire logic common_logic_clock_in,
    input wire rigc_pkg::rigc_ctrl_s bus_control_inputs_in,
    input wire logic below_lockout_in,
    // configuration
    input wire logic [7:0] mm_default_in,
    // software register writes
    input wire logic pm_a_wr_in,
    input wire logic pm_b_wr_in,
    input wire logic mm_wr_in,
    input wire logic [7:0] wr_data_in,
    // power down and port requests
    input wire logic pd_enter_in,
    input wire logic [PORT_W-1:0] io_dir_req_in,
    input wire logic addr_oe_req_in,
    input wire logic data_oe_req_in,
    // flash engine
    input wire logic flash_busy_in,
    // memory enables
    output logic flash_en_out,
    output logic boot_en_out,
    output logic sram_en_out,
    output logic io_en_out,
    // general_logic_array feeds and memory controls
    output logic array_clk_out,
    output rigc_pkg::rigc_ctrl_s array_ctrl_out,
    output rigc_pkg::rigc_ctrl_s mem_ctrl_out,
    output logic pld_valid_out,
    // status
    output logic in_reset_out,
    output logic access_ready_out,
    output logic power_down_out,
    output logic [7:0] pm_a_out,
    output logic [7:0] pm_b_out,
    output logic [7:0] mm_out,
    // port drivers
    output logic [PORT_W-1:0] io_port_oe_out,
    output logic addr_oe_out,
    output logic data_oe_out,
    // flash control
    output logic flash_abort_out,
    output logic flash_read_mode_out,
    output logic flash_write_allow_out
);
    import rigc_pkg::*;

    // *************************************
    // pin synchronisers
    // *************************************
    localparam int SYNC_W = 8;
    localparam int ABORT_MAX = `RIGC_ABORT_CYC;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic rst_pin_s;
    logic lockout_s;
    logic clk_s;
    rigc_ctrl_s ctrl_s;
    rigc_state_s state_reg;
    rigc_state_s state_next;
    logic running;
    logic rst_rise;

    initial begin
        // port enables live in the fixed-width state struct
        if (PORT_W != 8) begin
            $error("rigc_ctrl: PORT_W must be 8");
        end
        if (`RIGC_RECOVERY_CYC > 15 || `RIGC_ABORT_CYC > 4095) begin
            $error("rigc_ctrl: timing counts exceed counter widths");
        end
    end

    assign pins_raw = {ext_reset_n_in, below_lockout_in, common_logic_clock_in,
                       bus_control_inputs_in};

    // reset value 0 keeps the device in reset until the pin is seen high
    rigc_sync #(
        .W(SYNC_W),
        .RST_VAL(1'b0)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .nrst_in(nrst_in),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    assign rst_pin_s = pins_s[7];
    assign lockout_s = pins_s[6];
    assign clk_s = pins_s[5];
    assign ctrl_s = rigc_ctrl_s'(pins_s[4:0]);

    // *************************************
    // sequencing
    // *************************************
    assign running = (state_reg.phase == PH_RUN);
    assign rst_rise = (state_reg.phase == PH_RESET) && rst_pin_s;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg.phase)
            PH_RESET: begin
                // first pulse after supply is power-on, later ones warm
                if (!state_reg.powered) begin
                    state_next.pm_a = `RIGC_PM_RESET_VAL;
                    state_next.pm_b = `RIGC_PM_RESET_VAL;
                    state_next.cfg_loaded = 1'b1;
                end
                state_next.mm = mm_default_in;
                state_next.mm[`RIGC_MM_SRAM_CODE_BIT] = 1'b0;
                state_next.io_oe = '0;
                state_next.addr_oe = 1'b0;
                state_next.data_oe = 1'b0;
                if (rst_pin_s) begin
                    state_next.phase = PH_RECOVER;
                    state_next.rec_cnt = 4'(`RIGC_RECOVERY_CYC - 1);
                    state_next.powered = 1'b1;
                    state_next.pd = 1'b0;
                end
            end
            PH_RECOVER: begin
                if (!rst_pin_s) begin
                    state_next.phase = PH_RESET;
                end else if (state_reg.rec_cnt == 4'h0) begin
                    state_next.phase = PH_RUN;
                end else begin
                    state_next.rec_cnt = state_reg.rec_cnt - 4'h1;
                end
            end
            PH_RUN: begin
                if (!rst_pin_s) begin
                    state_next.phase = PH_RESET;
                end else begin
                    if (pm_a_wr_in) begin
                        state_next.pm_a = wr_data_in;
                    end
                    if (pm_b_wr_in) begin
                        state_next.pm_b = wr_data_in;
                    end
                    if (mm_wr_in) begin
                        state_next.mm = wr_data_in;
                    end
                    // power down: I/O holds, data floats, registers kept
                    if (state_reg.pd) begin
                        state_next.data_oe = 1'b0;
                        state_next.addr_oe = 1'b0;
                        if (!chip_select_pin_n_in) begin
                            state_next.pd = 1'b0;
                        end
                    end else begin
                        state_next.io_oe = io_dir_req_in;
                        state_next.addr_oe = addr_oe_req_in;
                        state_next.data_oe = data_oe_req_in;
                        state_next.pd = pd_enter_in;
                    end
                end
            end
        endcase

        // flash: reset kills a program or erase, read mode back by the deadline
        if (state_reg.phase == PH_RESET && flash_busy_in && !state_reg.aborting) begin
            state_next.aborting = 1'b1;
            state_next.abort_cnt = 12'(`RIGC_ABORT_CYC - 1);
            state_next.flash_read_mode = 1'b0;
        end else if (state_reg.aborting) begin
            if (state_reg.abort_cnt == 12'h000 || !flash_busy_in) begin
                state_next.aborting = 1'b0;
                state_next.flash_read_mode = 1'b1;
            end else begin
                state_next.abort_cnt = state_reg.abort_cnt - 12'h001;
            end
        end else if (running) begin
            state_next.flash_read_mode = !flash_busy_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state_reg <= '{phase: PH_RESET, powered: 1'b0, cfg_loaded: 1'b0, pd: 1'b0,
                           rec_cnt: 4'h0, abort_cnt: 12'h000, aborting: 1'b0,
                           flash_read_mode: 1'b1,
                           pm_a: 8'h00, pm_b: 8'h00, mm: 8'h00, io_oe: '0,
                           addr_oe: 1'b0, data_oe: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // *************************************
    // outputs
    // *************************************
    assign in_reset_out = !running;
    assign access_ready_out = running && !state_reg.pd;
    assign power_down_out = state_reg.pd;
    // combinational on purpose: enables follow the select in the same cycle
    assign flash_en_out = access_ready_out && !chip_select_pin_n_in;
    assign boot_en_out = access_ready_out && !chip_select_pin_n_in;
    assign sram_en_out = access_ready_out && !chip_select_pin_n_in;
    assign io_en_out = access_ready_out && !chip_select_pin_n_in;
    assign array_clk_out = clk_s && !state_reg.pm_a[`RIGC_PMA_CLK_BLOCK_BIT];
    assign array_ctrl_out = ctrl_s
        & ~state_reg.pm_b[`RIGC_PMB_LAST_BIT:`RIGC_PMB_FIRST_BIT];
    assign mem_ctrl_out = ctrl_s;
    assign pld_valid_out = state_reg.cfg_loaded;
    assign pm_a_out = state_reg.pm_a;
    assign pm_b_out = state_reg.pm_b;
    assign mm_out = state_reg.mm;
    assign io_port_oe_out = state_reg.io_oe;
    assign addr_oe_out = state_reg.addr_oe;
    assign data_oe_out = state_reg.data_oe;
    assign flash_abort_out = state_reg.aborting;
    assign flash_read_mode_out = state_reg.flash_read_mode;
    assign flash_write_allow_out = running && !lockout_s;

    // *************************************
    // checks
    // *************************************
    logic [12:0] abort_age_reg;

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in || !state_reg.aborting) begin
            abort_age_reg <= 13'h0000;
        end else begin
            abort_age_reg <= abort_age_reg + 13'h0001;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    a_cs_mem_gate: assert property (
        (access_ready_out && !chip_select_pin_n_in) |-> (flash_en_out && sram_en_out)
    ) else $error("memories not enabled with select low");
    a_cs_high_off: assert property (
        chip_select_pin_n_in |-> !(flash_en_out || boot_en_out || sram_en_out)
    ) else $error("memories enabled with select high");
    a_clk_block: assert property (
        ($past(nrst_in, 2) && $past(nrst_in))
        |-> array_clk_out == ($past(common_logic_clock_in, 2)
            && !state_reg.pm_a[`RIGC_PMA_CLK_BLOCK_BIT])
    ) else $error("array clock does not follow pin and block bit");
    a_ctrl_block: assert property (
        (array_ctrl_out & state_reg.pm_b[6:2]) == 5'h00 && (mem_ctrl_out == ctrl_s)
    ) else $error("blocked control reaches array or memory lost it");
    a_recover_len: assert property (
        disable iff (!nrst_in || !rst_pin_s)
        (rst_rise ##1 1'b1) |-> in_reset_out[*8] ##1 in_reset_out[*4] ##1 !in_reset_out
    ) else $error("recovery interval is not twelve cycles");
    a_por_clear: assert property (
        (state_reg.phase == PH_RESET && !state_reg.powered)
        |=> (pm_a_out == 8'h00 && pm_b_out == 8'h00)
    ) else $error("power-on reset left power registers set");
    a_warm_keep: assert property (
        (state_reg.phase == PH_RESET && state_reg.powered)
        |=> $stable(pm_a_out) && $stable(pm_b_out)
    ) else $error("warm reset changed power registers");
    a_sram_bit: assert property (
        (state_reg.phase == PH_RESET) |=> !mm_out[`RIGC_MM_SRAM_CODE_BIT]
    ) else $error("sram code bit not cleared by reset");
    a_lockout_wr: assert property (
        lockout_s |-> !flash_write_allow_out
    ) else $error("flash write allowed below lockout");
    a_abort_bound: assert property (
        abort_age_reg <= 13'(ABORT_MAX)
    ) else $error("flash abort exceeded its deadline");
    a_reset_float: assert property (
        (state_reg.phase == PH_RESET)
        |=> (io_port_oe_out == '0 && !addr_oe_out && !data_oe_out)
    ) else $error("port drivers active during reset");
    a_pd_exit: assert property (
        (running && rst_pin_s && state_reg.pd && !chip_select_pin_n_in) |=> !power_down_out
    ) else $error("select low did not leave power down");
    a_pld_valid: assert property (
        state_reg.powered |-> pld_valid_out
    ) else $error("logic outputs invalid after configuration");
endmodule

/* File: tb/rigc_partner.sv */
module rigc_partner #(
    parameter int POR_CYC = 20
) (
    // clock
    input wire logic core_clk_in,
    // requests from the bench
    input wire logic start_in,
    input wire logic [15:0] width_in,
    input wire logic [2:0] wr_raw_in,
    // device status
    input wire logic access_ready_in,
    // pins
    output logic ext_reset_n_out,
    output logic [2:0] wr_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // power-on width shortened from 1 ms so the run stays short
    logic [15:0] cnt = 16'(POR_CYC);
    always @(posedge core_clk_in) begin
        if (start_in) begin
            cnt <= (width_in < 16'h000F) ? 16'h000F : width_in;
        end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
        end
    end
    assign ext_reset_n_out = (cnt == 16'h0000);
    assign busy_out = (cnt != 16'h0000);
    // no strobe reaches the device until it reports ready
    assign wr_out = access_ready_in ? wr_raw_in : 3'h0;
endmodule

/* File: tb/tb_rigc_ctrl.sv */
module tb_rigc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import rigc_pkg::*;
    logic clk = 1'b0, nrst_n = 1'b0, rst_n, cs_n = 1'b1, cclk = 1'b0, low = 1'b0;
    rigc_ctrl_s ctl = 5'h00, actl, mctl;
    logic [7:0] mmd = 8'hA5, wd = 8'h00, iodir = 8'h3C, io_oe, pma, pmb, mm;
    logic [2:0] wraw = 3'h0, wr;
    logic pd = 1'b0, aoe_r = 1'b1, doe_r = 1'b1, fbusy = 1'b0, start = 1'b0, pbusy;
    logic fen, ben, sen, ien, aclk, pldv, inr, rdy, pdo, aoe, doe, abt, frm, fwa;
    logic [15:0] width = 16'h0000;
    int fail_count = 0, samples_checked = 0, n;
    always #5 clk = ~clk;
    rigc_partner #(.POR_CYC(20)) partner (.core_clk_in(clk), .start_in(start),
        .width_in(width), .wr_raw_in(wraw), .access_ready_in(rdy),
        .ext_reset_n_out(rst_n), .wr_out(wr), .busy_out(pbusy));
    rigc_ctrl #(.PORT_W(8)) dut (.core_clk_in(clk), .nrst_in(nrst_n),
        .ext_reset_n_in(rst_n), .chip_select_pin_n_in(cs_n),
        .common_logic_clock_in(cclk), .bus_control_inputs_in(ctl),
        .below_lockout_in(low), .mm_default_in(mmd), .pm_a_wr_in(wr[0]),
        .pm_b_wr_in(wr[1]), .mm_wr_in(wr[2]), .wr_data_in(wd), .pd_enter_in(pd),
        .io_dir_req_in(iodir), .addr_oe_req_in(aoe_r), .data_oe_req_in(doe_r),
        .flash_busy_in(fbusy), .flash_en_out(fen), .boot_en_out(ben),
        .sram_en_out(sen), .io_en_out(ien), .array_clk_out(aclk),
        .array_ctrl_out(actl), .mem_ctrl_out(mctl), .pld_valid_out(pldv),
        .in_reset_out(inr), .access_ready_out(rdy), .power_down_out(pdo),
        .pm_a_out(pma), .pm_b_out(pmb), .mm_out(mm), .io_port_oe_out(io_oe),
        .addr_oe_out(aoe), .data_oe_out(doe), .flash_abort_out(abt),
        .flash_read_mode_out(frm), .flash_write_allow_out(fwa));
    // *************************************
    // tasks
    // *************************************
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic write(input int sel, input logic [7:0] d);
        wd = d;
        wraw = 3'(1 << sel);
        tick(1);
        wraw = 3'h0;
        tick(1);
    endtask
    // pulse the pin, return cycles from pin rise until in_reset drops
    task automatic pulse(input logic [15:0] w);
        width = w;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(2);
        n = 0;
        while (pbusy === 1'b1 && n < 5000) begin
            tick(1);
            n++;
        end
        n = 0;
        while (inr !== 1'b0 && n < 40) begin
            tick(1);
            n++;
        end
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #200us;
        fail_count++;
        end_sim;
    end
    // *************************************
    // tests
    // *************************************
    initial begin
        tick(8);
        nrst_n = 1'b1;
        tick(3);
        check("inr", inr, 1);
        check("io_oe", io_oe, 0);
        check("oe", {aoe, doe}, 0);
        check("pma", pma, 0);
        check("frm", frm, 1);
        check("pldv", pldv, 1);
        n = 0;
        while (inr !== 1'b0 && n < 60) begin
            tick(1);
            n++;
        end
        check("mm", mm, 8'hA4);
        check("rdy", rdy, 1);
        $display("power-on done");
        cs_n = 1'b0;
        #1;
        check("en", {fen, ben, sen, ien}, 8'h0F);
        cs_n = 1'b1;
        #1;
        check("en", {fen, ben, sen, ien}, 8'h00);
        cclk = 1'b1;
        tick(3);
        check("aclk", aclk, 1);
        write(0, 8'h10);
        check("aclk", aclk, 0);
        write(0, 8'h00);
        check("aclk", aclk, 1);
        ctl = 5'h1F;
        for (int b = 2; b <= 6; b++) begin
            write(1, 8'(1 << b));
            check("actl", actl, 8'(5'h1F & ~(5'h01 << (b - 2))));
            check("mctl", mctl, 8'h1F);
        end
        $display("gating done");
        write(0, 8'h10);
        write(2, 8'hFF);
        check("mm", mm, 8'hFF);
        pulse(16'h000F);
        check("rec", 8'(n >= 12 && n <= 16), 1);
        check("pma", pma, 8'h10);
        check("pmb", pmb, 8'h40);
        check("mm", mm, 8'hA4);
        check("pldv", pldv, 1);
        $display("warm reset done");
        low = 1'b1;
        tick(4);
        check("fwa", fwa, 0);
        low = 1'b0;
        tick(4);
        check("fwa", fwa, 1);
        tick(6);
        check("oe", {aoe, doe}, 8'h03);
        check("io_oe", io_oe, 8'h3C);
        pd = 1'b1;
        tick(4);
        pd = 1'b0;
        check("pdo", pdo, 1);
        check("rdy", rdy, 0);
        check("doe", doe, 0);
        check("io_oe", io_oe, 8'h3C);
        check("pma", pma, 8'h10);
        cs_n = 1'b0;
        tick(2);
        check("pdo", pdo, 0);
        cs_n = 1'b1;
        $display("power down done");
        fbusy = 1'b1;
        width = 16'h000F;
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(4);
        check("abt", abt, 1);
        n = 0;
        while ((abt !== 1'b0 || frm !== 1'b1) && n < 2600) begin
            tick(1);
            n++;
        end
        check("abort_time", 8'(n <= 2500), 1);
        check("frm", frm, 1);
        fbusy = 1'b0;
        tick(30);
        $display("flash abort done");
        end_sim;
    end
endmodule
